// >>> agcgl_defines.vh
/*
 * Constants for the per-channel gain loop: widths, limits, table base
 * and the exponent alignment delay. Included by the gain-loop design file.
 */
`ifndef AGCGL_DEFINES_VH
`define AGCGL_DEFINES_VH

// ----------------------------------------
// Widths
// ----------------------------------------
`define AGCGL_ADC_W 12
`define AGCGL_PWR_W 9
`define AGCGL_CODE_W 5
`define AGCGL_LUT_DEPTH 32
`define AGCGL_LUT_W 8
`define AGCGL_INT_W 11
`define AGCGL_GAIN_W 3
`define AGCGL_MIX_W 15
`define AGCGL_SHUP_W 22

// ----------------------------------------
// Loop constants
// ----------------------------------------
`define AGCGL_DECIM 8
`define AGCGL_DECIM_LOG2 3
`define AGCGL_INT_MAX 11'h7FF
`define AGCGL_INT_MIN 11'h000
`define AGCGL_LUT_BASE 8'h80
`define AGCGL_SHIFT_BASE 8
`define AGCGL_EXP_DELAY 6
`define AGCGL_FIFO_DEPTH 4

`endif

// >>> agcgl_fifo.v
/*
 * Small flip-flop FIFO with valid/ready on both sides.
 * Assumes a single clock and synchronous active-low reset.
 */
`timescale 1ns/1ps
module agcgl_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 4,
  parameter AW = 2
) (
  // Clock and reset
  input wire clk,
  input wire reset_n,
  // Fill side
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  // Drain side
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem_q [0:DEPTH-1];
  reg [AW-1:0] wr_q;
  reg [AW-1:0] rd_q;
  reg [AW:0] cnt_q;
  reg [AW:0] cnt_d;
  reg in_ready_q;
  wire push;
  wire pop;
  // Ready comes from a flop so the fill-side pin carries no decode logic
  assign in_ready = in_ready_q;
  assign out_valid = (cnt_q != {(AW+1){1'b0}});
  assign out_data = mem_q[rd_q];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  always @* begin
    cnt_d = cnt_q;
    if (push && !pop)
      cnt_d = cnt_q + 1'b1;
    else if (pop && !push)
      cnt_d = cnt_q - 1'b1;
  end
  always @(posedge clk) begin
    if (!reset_n) begin
      wr_q <= {AW{1'b0}};
      rd_q <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
      in_ready_q <= 1'b1;
    end else begin
      cnt_q <= cnt_d;
      in_ready_q <= (cnt_d != DEPTH[AW:0]);
      if (push) begin
        mem_q[wr_q] <= in_data;
        wr_q <= (wr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_q + 1'b1;
      end
      if (pop)
        rd_q <= (rd_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_q + 1'b1;
    end
  end
endmodule // agcgl_fifo

// >>> agcgl_gain_loop.v
/*
 * Dual-channel automatic gain loop: power detector, fixed-to-float code,
 * table lookup, loop shift, saturating integrator, amplifier interface
 * and the aligned digital exponent with the mixer shift-up.
 * Assumes synchronous inputs on clk; table writes come as plain strobes.
 */
// Operation
// - Each channel drives a 3-bit gain word, 6dB per code step.
// - Outside reset and sync, a channel strobe pulses high only when its gain word changed last cycle.
// - Channel A and B strobes are independent outside master reset and sync.
// - Both strobes are asserted while master reset or sync is active.
// - Power is absolute value then two-stage comb, decimating by eight.
// - The 9-bit power becomes a 5-bit exponent and mantissa code.
// - Exponent is leading-one position minus one; mantissa the two bits below; powers under 4 give exponent 0 and mantissa bits 1:0.
// - The code addresses a 32x8 signed table loaded by software.
// - Table output scaled by two to the shift count minus eight.
// - Integrator accumulates, loadable from each channel's own initial value.
// - Top eight integrator bits are readable per channel.
// - Gain word is the top three integrator bits, sent with strobe.
// - 11-bit integrator saturates at 0 and 2047, never wraps.
// - Digital exponent is the bitwise inverse of the gain word.
// - 15-bit mixer word is placed in a 22-bit field by exponent.
// - Hold low runs the loop; hold high pins integrator to initial value.
// - While held, inverted top bits of initial value drive the gain word.
// - Exponent inhibit clear passes the exponent; set applies no compensation.
`timescale 1ns/1ps
`include "agcgl_defines.vh"
module agcgl_gain_loop #(
  parameter ADC_W = `AGCGL_ADC_W,
  parameter EXP_DELAY = `AGCGL_EXP_DELAY,
  parameter FIFO_DEPTH = `AGCGL_FIFO_DEPTH
) (
  // Clock and reset
  input wire clk,
  input wire reset_n,
  input wire master_reset_pin_n,
  input wire sync_in_n,
  // Samples
  input wire signed [ADC_W-1:0] adc_a,
  input wire signed [ADC_W-1:0] adc_b,
  // Control
  input wire [1:0] loop_shift_count,
  input wire integrator_hold,
  input wire exponent_inhibit,
  input wire [7:0] integrator_init_chan_a,
  input wire [7:0] integrator_init_chan_b,
  // Table load
  input wire lut_wr_en,
  input wire [7:0] lut_wr_addr,
  input wire [7:0] lut_wr_data,
  // Mixer words in, shifted words out
  input wire mix_valid,
  output wire mix_ready,
  input wire [2*`AGCGL_MIX_W-1:0] mix_data,
  output reg shup_valid_q,
  input wire shup_ready,
  output reg [`AGCGL_SHUP_W-1:0] shup_a_q,
  output reg [`AGCGL_SHUP_W-1:0] shup_b_q,
  // Amplifier interface and readback
  output reg [2:0] analog_gain_word_a_q,
  output reg [2:0] analog_gain_word_b_q,
  output reg gain_strobe_chan_a,
  output reg gain_strobe_chan_b,
  output reg [7:0] integrator_readback_chan_a,
  output reg [7:0] integrator_readback_chan_b,
  output reg [2:0] digital_gain_exponent_a_q,
  output reg [2:0] digital_gain_exponent_b_q
);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function [ADC_W-1:0] abs_val;
    input [ADC_W-1:0] x;
    begin
      abs_val = x[ADC_W-1] ? (~x + 1'b1) : x;
    end
  endfunction

  function [4:0] to_float;
    input [8:0] p;
    begin
      if (p[8]) to_float = {3'h7, p[7:6]};
      else if (p[7]) to_float = {3'h6, p[6:5]};
      else if (p[6]) to_float = {3'h5, p[5:4]};
      else if (p[5]) to_float = {3'h4, p[4:3]};
      else if (p[4]) to_float = {3'h3, p[3:2]};
      else if (p[3]) to_float = {3'h2, p[2:1]};
      else if (p[2]) to_float = {3'h1, p[1:0]};
      else to_float = {3'h0, p[1:0]};
    end
  endfunction

  // Scaled error: table value times 2^(shift-8), kept as 13-bit signed
  function signed [12:0] scale_err;
    input [7:0] v;
    input [1:0] sh;
    reg signed [12:0] w;
    begin
      w = {{5{v[7]}}, v};
      scale_err = (w <<< sh) >>> 8;
    end
  endfunction

  function [10:0] sat_add;
    input [10:0] acc;
    input signed [12:0] e;
    reg signed [13:0] s;
    begin
      s = $signed({3'h0, acc}) + {e[12], e};
      if (s < 14'sh0) sat_add = `AGCGL_INT_MIN;
      else if (s > $signed({3'h0, `AGCGL_INT_MAX})) sat_add = `AGCGL_INT_MAX;
      else sat_add = s[10:0];
    end
  endfunction

  function [21:0] shift_up;
    input [14:0] m;
    input [2:0] e;
    reg signed [21:0] w;
    begin
      w = {m, 7'h00};
      shift_up = w >>> (3'h7 - e);
    end
  endfunction

  // ----------------------------------------
  // Power detector and lookup, both channels
  // ----------------------------------------
  wire init_act = !master_reset_pin_n || !sync_in_n;
  reg [2:0] phase_q;
  reg [7:0] lut_q [0:`AGCGL_LUT_DEPTH-1];
  reg [ADC_W+5:0] acc1_q [0:1];
  reg [ADC_W+5:0] acc2_q [0:1];
  reg [ADC_W+5:0] dly1_q [0:1];
  reg [ADC_W+5:0] dly2_q [0:1];
  reg [4:0] code_q [0:1];
  reg code_vld_q;
  reg [10:0] int_q [0:1];
  reg [2:0] gain_d [0:1];
  reg [2:0] gain_prev_q [0:1];
  reg [3*EXP_DELAY-1:0] exp_pipe_q [0:1];
  wire [ADC_W-1:0] adc_in [0:1];
  wire [7:0] init_v [0:1];
  reg [ADC_W+5:0] c1 [0:1];
  reg [ADC_W+5:0] c2 [0:1];
  integer ch;
  integer i;
  integer j;
  assign adc_in[0] = adc_a;
  assign adc_in[1] = adc_b;
  assign init_v[0] = integrator_init_chan_a;
  assign init_v[1] = integrator_init_chan_b;

  always @(posedge clk) begin
    if (lut_wr_en && lut_wr_addr[7:5] == `AGCGL_LUT_BASE >> 5)
      lut_q[lut_wr_addr[4:0]] <= lut_wr_data;
  end

  // Comb differences at the decimation point, one pair per channel
  always @* begin
    for (j = 0; j < 2; j = j + 1) begin
      c1[j] = acc2_q[j] - dly1_q[j];
      c2[j] = c1[j] - dly2_q[j];
    end
  end

  // Two integrators at the input rate, two combs at the decimated rate
  always @(posedge clk) begin
    if (!reset_n || init_act) begin
      phase_q <= 3'h0;
      code_vld_q <= 1'b0;
      for (ch = 0; ch < 2; ch = ch + 1) begin
        acc1_q[ch] <= {(ADC_W+6){1'b0}};
        acc2_q[ch] <= {(ADC_W+6){1'b0}};
        dly1_q[ch] <= {(ADC_W+6){1'b0}};
        dly2_q[ch] <= {(ADC_W+6){1'b0}};
        code_q[ch] <= 5'h00;
      end
    end else begin
      phase_q <= phase_q + 1'b1;
      code_vld_q <= (phase_q == 3'h7);
      for (ch = 0; ch < 2; ch = ch + 1) begin
        acc1_q[ch] <= acc1_q[ch] + {6'h00, abs_val(adc_in[ch])};
        acc2_q[ch] <= acc2_q[ch] + acc1_q[ch];
        if (phase_q == 3'h7) begin
          dly1_q[ch] <= acc2_q[ch];
          dly2_q[ch] <= c1[ch];
          // Gain of 64 puts an 11-bit magnitude in bits 16:6, read as 16:8; only a full-scale
          // negative run reaches the top bit, so clamp rather than wrap
          code_q[ch] <= to_float(c2[ch][ADC_W+5] ? 9'h1FF : c2[ch][ADC_W+4:ADC_W-4]);
        end
      end
    end
  end

  // ----------------------------------------
  // Integrator, gain word and strobes
  // ----------------------------------------
  always @* begin
    for (i = 0; i < 2; i = i + 1) begin
      if (integrator_hold)
        gain_d[i] = ~init_v[i][7:5];
      else
        gain_d[i] = int_q[i][10:8];
    end
  end

  always @(posedge clk) begin
    if (!reset_n || init_act) begin
      for (ch = 0; ch < 2; ch = ch + 1) begin
        int_q[ch] <= {init_v[ch], 3'h0} & 11'h000;
        gain_prev_q[ch] <= 3'h0;
      end
      analog_gain_word_a_q <= 3'h0;
      analog_gain_word_b_q <= 3'h0;
      gain_strobe_chan_a <= 1'b1;
      gain_strobe_chan_b <= 1'b1;
      integrator_readback_chan_a <= 8'h00;
      integrator_readback_chan_b <= 8'h00;
    end else begin
      for (ch = 0; ch < 2; ch = ch + 1) begin
        if (integrator_hold)
          int_q[ch] <= {init_v[ch], 3'h0};
        else if (code_vld_q)
          int_q[ch] <= sat_add(int_q[ch], scale_err(lut_q[code_q[ch]], loop_shift_count));
        gain_prev_q[ch] <= gain_d[ch];
      end
      analog_gain_word_a_q <= gain_d[0];
      analog_gain_word_b_q <= gain_d[1];
      // Each strobe compares only its own channel's word
      gain_strobe_chan_a <= (gain_d[0] != gain_prev_q[0]);
      gain_strobe_chan_b <= (gain_d[1] != gain_prev_q[1]);
      integrator_readback_chan_a <= int_q[0][10:3];
      integrator_readback_chan_b <= int_q[1][10:3];
    end
  end

  // ----------------------------------------
  // Exponent alignment
  // ----------------------------------------
  // Shift line sized by a fixed latency; does not track a changing ADC latency
  always @(posedge clk) begin
    if (!reset_n) begin
      exp_pipe_q[0] <= {(3*EXP_DELAY){1'b1}};
      exp_pipe_q[1] <= {(3*EXP_DELAY){1'b1}};
      digital_gain_exponent_a_q <= 3'h7;
      digital_gain_exponent_b_q <= 3'h7;
    end else begin
      for (ch = 0; ch < 2; ch = ch + 1)
        exp_pipe_q[ch] <= {exp_pipe_q[ch][3*EXP_DELAY-4:0], ~gain_d[ch]};
      digital_gain_exponent_a_q <= exponent_inhibit ? 3'h7 : exp_pipe_q[0][3*EXP_DELAY-1 -: 3];
      digital_gain_exponent_b_q <= exponent_inhibit ? 3'h7 : exp_pipe_q[1][3*EXP_DELAY-1 -: 3];
    end
  end

  // ----------------------------------------
  // Mixer buffer and shift-up
  // ----------------------------------------
  wire f_valid;
  wire [2*`AGCGL_MIX_W-1:0] f_data;
  wire f_pop = f_valid && (!shup_valid_q || shup_ready);
  agcgl_fifo #(
    .WIDTH(2*`AGCGL_MIX_W),
    .DEPTH(FIFO_DEPTH),
    .AW(2)
  ) u_fifo (
    .clk(clk),
    .reset_n(reset_n),
    .in_valid(mix_valid),
    .in_ready(mix_ready),
    .in_data(mix_data),
    .out_valid(f_valid),
    .out_ready(f_pop),
    .out_data(f_data)
  );

  always @(posedge clk) begin
    if (!reset_n) begin
      shup_valid_q <= 1'b0;
      shup_a_q <= 22'h000000;
      shup_b_q <= 22'h000000;
    end else begin
      if (f_pop) begin
        shup_valid_q <= 1'b1;
        shup_a_q <= shift_up(f_data[14:0], digital_gain_exponent_a_q);
        shup_b_q <= shift_up(f_data[29:15], digital_gain_exponent_b_q);
      end else if (shup_ready)
        shup_valid_q <= 1'b0;
    end
  end
endmodule // agcgl_gain_loop

// >>> agcgl_amp_model.sv
/* Stepped-gain amplifier model for one channel.
   Assumes the gain word and strobe come from the gain loop on clk. */
`timescale 1ns/1ps
module agcgl_amp_model (
  // Clock
  input wire clk,
  // Amplifier pins
  input wire [2:0] gain_word,
  input wire strobe,
  // Setting in force, 6 dB per step
  output reg [2:0] latched_q
);
  // Latching only on strobe exposes a strobe that lags or misses a word change
  always @(posedge clk)
    if (strobe) latched_q <= gain_word;
endmodule // agcgl_amp_model

// >>> agcgl_gain_loop_checker.sv
/* Port checker for agcgl_gain_loop: strobes, exponent, hold, update rate.
   Assumes one clock and synchronous active-low reset; bound below. */
`timescale 1ns/1ps
module agcgl_checker (
  // Clock and reset
  input wire clk,
  input wire reset_n,
  input wire master_reset_pin_n,
  input wire sync_in_n,
  // Control
  input wire integrator_hold,
  input wire exponent_inhibit,
  input wire [7:0] integrator_init_chan_a,
  // Outputs
  input wire [2:0] analog_gain_word_a_q,
  input wire [2:0] analog_gain_word_b_q,
  input wire gain_strobe_chan_a,
  input wire gain_strobe_chan_b,
  input wire [7:0] integrator_readback_chan_a,
  input wire [2:0] digital_gain_exponent_a_q
);
  wire ok = master_reset_pin_n & sync_in_n;
  reg [1:0] up_q;
  // Strobes are forced in reset and sync, so wait a few cycles before judging them
  always @(posedge clk)
    if (!reset_n || !ok) up_q <= 2'h0;
    else if (up_q != 2'h3) up_q <= up_q + 2'h1;
  wire run = up_q == 2'h3;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  strobe_init_a: assert property (!ok |=> gain_strobe_chan_a && gain_strobe_chan_b)
    else $error("strobe low in master reset or sync");
  strobe_cause_a: assert property (run && gain_strobe_chan_a |->
    analog_gain_word_a_q != $past(analog_gain_word_a_q) || $past(analog_gain_word_a_q) != $past(analog_gain_word_a_q, 2))
    else $error("strobe a without gain change");
  strobe_cause_b: assert property (run && gain_strobe_chan_b |->
    analog_gain_word_b_q != $past(analog_gain_word_b_q) || $past(analog_gain_word_b_q) != $past(analog_gain_word_b_q, 2))
    else $error("strobe b without gain change");
  strobe_follow_a: assert property (run && $changed(analog_gain_word_a_q) |-> ##[0:2] gain_strobe_chan_a)
    else $error("gain change without strobe");
  exp_inhibit_a: assert property ((ok && exponent_inhibit) [*8] |-> digital_gain_exponent_a_q == 3'h7)
    else $error("exponent not forced under inhibit");
  exp_track_a: assert property ((ok && !exponent_inhibit && $stable(analog_gain_word_a_q)) [*8]
    |-> digital_gain_exponent_a_q == ~analog_gain_word_a_q) else $error("exponent not inverse of gain");
  hold_fix_a: assert property ((ok && integrator_hold && $stable(integrator_init_chan_a)) [*4] |->
    analog_gain_word_a_q == ~integrator_init_chan_a[7:5] && integrator_readback_chan_a == integrator_init_chan_a)
    else $error("held gain wrong");
  update_rate_a: assert property (run && !integrator_hold && $changed(integrator_readback_chan_a) |=>
    (integrator_hold || !ok || $stable(integrator_readback_chan_a)) [*7]) else $error("integrator updates too often");
  cover property (run && gain_strobe_chan_a);
  cover property (integrator_hold && gain_strobe_chan_a);
  cover property (exponent_inhibit && digital_gain_exponent_a_q == 3'h7);
endmodule // agcgl_checker
bind agcgl_gain_loop agcgl_checker u_chk (.clk(clk), .reset_n(reset_n), .master_reset_pin_n(master_reset_pin_n),
  .sync_in_n(sync_in_n), .integrator_hold(integrator_hold), .exponent_inhibit(exponent_inhibit),
  .integrator_init_chan_a(integrator_init_chan_a), .analog_gain_word_a_q(analog_gain_word_a_q),
  .analog_gain_word_b_q(analog_gain_word_b_q), .gain_strobe_chan_a(gain_strobe_chan_a),
  .gain_strobe_chan_b(gain_strobe_chan_b), .integrator_readback_chan_a(integrator_readback_chan_a),
  .digital_gain_exponent_a_q(digital_gain_exponent_a_q));

// >>> agcgl_gain_loop_bench.sv
/* Bench for agcgl_gain_loop: table load, saturation, sync, hold, strobes, FIFO.
   Assumes amplifier models on both channels; ADC inputs held at fixed levels. */
`timescale 1ns/1ps
module agcgl_gain_loop_bench;
  reg clk, reset_n, mst_n, si_n, hold, inh, we, mv, sr, took;
  reg [1:0] sh;
  reg [7:0] ia, ib, wa, wd;
  reg [11:0] aa, ab;
  reg [29:0] md;
  wire mrdy, sv, sa, sb;
  wire [21:0] oa, ob;
  wire [2:0] ga, gb, ea, eb, la, lb;
  wire [7:0] ra, rb;
  integer error_cnt, n_tests, k, na0, nb0;
  integer na = 0, nb = 0;
  reg [43:0] q[$];
  agcgl_gain_loop dut (.clk(clk), .reset_n(reset_n), .master_reset_pin_n(mst_n), .sync_in_n(si_n),
    .adc_a(aa), .adc_b(ab), .loop_shift_count(sh), .integrator_hold(hold),
    .exponent_inhibit(inh), .integrator_init_chan_a(ia), .integrator_init_chan_b(ib),
    .lut_wr_en(we), .lut_wr_addr(wa), .lut_wr_data(wd), .mix_valid(mv), .mix_ready(mrdy),
    .mix_data(md), .shup_valid_q(sv), .shup_ready(sr), .shup_a_q(oa), .shup_b_q(ob),
    .analog_gain_word_a_q(ga), .analog_gain_word_b_q(gb), .gain_strobe_chan_a(sa),
    .gain_strobe_chan_b(sb), .integrator_readback_chan_a(ra), .integrator_readback_chan_b(rb),
    .digital_gain_exponent_a_q(ea), .digital_gain_exponent_b_q(eb));
  agcgl_amp_model amp_a (.clk(clk), .gain_word(ga), .strobe(sa), .latched_q(la));
  agcgl_amp_model amp_b (.clk(clk), .gain_word(gb), .strobe(sb), .latched_q(lb));
  function [21:0] sh22(input [14:0] m, input [2:0] e);
    sh22 = {{7{m[14]}}, m} << e;
  endfunction
  task chk(input [43:0] got, input [43:0] want);
    n_tests++;
    if (got !== want) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h want=%h", $time, got, want);
    end
  endtask
  task end_sim;
    if (error_cnt == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task lut_wr(input [7:0] a, input [7:0] d);
    @(posedge clk);
    we <= 1'b1;
    wa <= a;
    wd <= d;
    @(posedge clk);
    we <= 1'b0;
  endtask
  task chk_state(input [7:0] r, input [2:0] g);
    @(negedge clk);
    chk({ra, rb, ga, gb, la, lb, ea, eb}, {r, r, g, g, g, g, ~g, ~g});
  endtask
  // Offers a word only while ready is seen high, so a full buffer ends the fill
  task push(input [14:0] a, input [14:0] b, input [2:0] xa, input [2:0] xb);
    @(negedge clk);
    took = mrdy === 1'b1;
    if (took) begin
      @(posedge clk);
      mv <= 1'b1;
      md <= {b, a};
      q.push_back({sh22(a, xa), sh22(b, xb)});
      @(posedge clk);
      mv <= 1'b0;
    end
  endtask
  task drain;
    @(posedge clk);
    sr <= 1'b1;
    for (k = 0; k < 20 && q.size() > 0; k++) begin
      @(negedge clk);
      if (sv === 1'b1) chk({oa, ob}, q.pop_front());
    end
    chk(q.size(), 0);
    @(posedge clk);
    sr <= 1'b0;
  endtask
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk)
    if (reset_n && mst_n && si_n) begin
      na <= na + sa;
      nb <= nb + sb;
    end
  initial begin
    repeat (70000) @(posedge clk);
    error_cnt++;
    end_sim;
  end
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    {reset_n, mst_n, hold, inh, we, mv, sr} = 7'h00;
    si_n = 1'b1;
    sh = 2'h3;
    {ia, ib, wa, wd, md, aa, ab} = 0;
    {error_cnt, n_tests} = 0;
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    @(negedge clk);
    chk({sa, sb}, 2'h3);
    @(posedge clk);
    mst_n <= 1'b1;
    for (k = 8'h80; k <= 8'h9F; k++) lut_wr(k[7:0], 8'h7F);
    lut_wr(8'h60, 8'h80);
    repeat (20000) @(posedge clk);
    chk_state(8'hFF, 3'h7);
    lut_wr(8'h80, 8'h80);
    repeat (20000) @(posedge clk);
    chk_state(8'h00, 3'h0);
    // Magnitude 64 gives power 16, code 0C; magnitude 176 gives power 44, code 11
    for (k = 0; k < 32; k++) lut_wr(8'h80 + k[7:0], (k == 12 || k == 17) ? 8'h7F : 8'h00);
    @(posedge clk);
    aa <= 12'h040;
    ab <= 12'hF50;
    repeat (8000) @(posedge clk);
    chk_state(8'hFF, 3'h7);
    @(posedge clk);
    si_n <= 1'b0;
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk({sa, sb}, 2'h3);
    @(posedge clk);
    si_n <= 1'b1;
    hold <= 1'b1;
    ia <= 8'hA0;
    ib <= 8'h40;
    repeat (20) @(posedge clk);
    @(negedge clk);
    chk({ra, rb}, 16'hA040);
    chk({ga, gb, la, lb}, 12'h555);
    na0 = na;
    nb0 = nb;
    @(posedge clk);
    ia <= 8'h20;
    repeat (20) @(posedge clk);
    @(negedge clk);
    chk({na[3:0] - na0[3:0], nb[3:0] - nb0[3:0]}, 8'h10);
    chk({ea, eb}, 6'h0A);
    took = 1'b1;
    for (k = 0; k < 10 && took; k++) push(15'h4000 | k[14:0], k[14:0], 3'h1, 3'h2);
    chk(q.size(), 5);
    drain;
    inh <= 1'b1;
    repeat (10) @(posedge clk);
    @(negedge clk);
    chk({ea, eb}, 6'h3F);
    push(15'h7FFF, 15'h0001, 3'h7, 3'h7);
    drain;
    end_sim;
  end
endmodule // agcgl_gain_loop_bench
